// [design/modbus_consts.svh]
// Purpose: constants for the request handler of a drive's coil and register space
// Assumes: byte stream delivered by a separate character layer
// Notes: codes and limits live here; frame field offsets are coded in the handler
//
// What this block does
// - write multiple coils sets each addressed coil from its force data bit
// - broadcast coil writes apply the same values to the same coils
// - coils 17 to 32 form the speed set-point word
// - coil write reply: address, function, start, count, check; no data
// - read holding registers returns the requested run of registers
// - wire addresses are zero based; register n travels as n minus one
// - read data: byte count, then two bytes per register, high first
// - a 32-bit parameter spans two registers, read with count two
// - preset single register writes the sixteen-bit value to one register
// - preset single reply echoes the request after the write is taken
// - preset multiple writes high-first words into consecutive registers
// - preset multiple reply: address, function, start, count, check
// - parameter number is the register address divided by ten
// - reads are never honoured as broadcasts
// - start plus length beyond the implemented range gives exception two
`ifndef MODBUS_CONSTS_SVH
`define MODBUS_CONSTS_SVH
`define FC_RD_HOLD    8'h03
`define FC_WR_SINGLE  8'h06
`define FC_WR_COILS   8'h0f
`define FC_WR_MULTI   8'h10
`define EXC_FLAG      8'h80
`define EXC_NONE      8'h00
`define EXC_ILL_FUNC  8'h01
`define EXC_ILL_ADDR  8'h02
`define EXC_ILL_VAL   8'h03
`define BCAST_ADDR    8'h00
`define NUM_REGS      16'h0040
`define NUM_COILS     16'h0020
`define MAX_QTY       16'h0010
`define BUF_DEPTH     64
`define MIN_FRAME     8'h04
`define FIXED_LEN     8'h08
`define HDR_LEN       9'h009
`define RESP_EXC_LEN  8'h03
`define RESP_ECHO_LEN 8'h06
`define PARAM_STRIDE  16'h000a
`define CRC_INIT      16'hffff
`define CRC_POLY      16'ha001
`define REG_RESET     16'h0000
`endif

// [design/modbus_pkg.sv]
// Purpose: shared types of the request handler
// Assumes: nothing
// Notes: byte carriers and drive-side images
package modbus_pkg;
  typedef logic [7:0] byte_t;

  typedef enum logic [3:0] {
    ST_IDLE  = 4'b0001,
    ST_CHECK = 4'b0010,
    ST_EXEC  = 4'b0100,
    ST_SEND  = 4'b1000
  } state_e;

  typedef struct packed {
    logic  valid;
    byte_t data;
    logic  frame_end;
  } rx_byte_s;

  typedef struct packed {
    logic  valid;
    byte_t data;
    logic  last;
  } tx_byte_s;

  typedef struct packed {
    logic [15:0] setpoint;
    logic [15:0] ctrl;
  } coil_image_s;

  typedef struct packed {
    logic        valid;
    logic [15:0] addr;
    logic [15:0] data;
  } reg_write_s;
endpackage : modbus_pkg

// [design/crc16_unit.sv]
// Purpose: running frame check over a byte stream
// Assumes: one byte per enable
// Notes: a frame ending in its own check leaves zero
`timescale 1ns/1ps
`include "modbus_consts.svh"
module crc16_unit
  import modbus_pkg::*;
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        reset,
  // byte feed
  input  wire logic        clr,
  input  wire logic        en,
  input  wire byte_t       data,
  // result
  output logic [15:0]      crc
);
  function automatic logic [15:0] crc_step(input logic [15:0] c, input byte_t d);
    logic [15:0] v;
    v = c ^ {8'h00, d};
    for (int i = 0; i < 8; i++) begin
      v = v[0] ? ((v >> 1) ^ `CRC_POLY) : (v >> 1);
    end
    return v;
  endfunction : crc_step

  always_ff @(posedge clk) begin
    if (reset || clr) begin
      crc <= `CRC_INIT;
    end else if (en) begin
      crc <= crc_step(crc, data);
    end
  end
endmodule : crc16_unit

// [design/holding_reg_file.sv]
// Purpose: holding register storage
// Assumes: one write and one read per cycle
// Notes: read is combinational
`timescale 1ns/1ps
`include "modbus_consts.svh"
module holding_reg_file
  import modbus_pkg::*;
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        reset,
  // write port
  input  wire logic        we,
  input  wire logic [5:0]  waddr,
  input  wire logic [15:0] wdata,
  // read port
  input  wire logic [5:0]  raddr,
  output logic [15:0]      rdata
);
  logic [15:0] mem_r [`BUF_DEPTH];

  always_ff @(posedge clk) begin
    if (reset) begin
      for (int i = 0; i < `BUF_DEPTH; i++) begin
        mem_r[i] <= `REG_RESET;
      end
    end else if (we) begin
      mem_r[waddr] <= wdata;
    end
  end

  assign rdata = mem_r[raddr];
endmodule : holding_reg_file

// [design/modbus_rtu_function_handler.sv]
// Purpose: slave request handler for functions 03, 06, 0f and 10
// Assumes: character layer marks frame end after the silent gap
// Notes: one request at a time; bytes arriving outside idle are dropped
`timescale 1ns/1ps
`include "modbus_consts.svh"
module modbus_rtu_function_handler
  import modbus_pkg::*;
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        reset,
  // station address
  input  wire byte_t       slave_addr,
  // received bytes
  input  wire rx_byte_s    rx,
  // reply bytes
  output tx_byte_s         tx,
  input  wire logic        tx_ready,
  // drive side
  output coil_image_s      coils,
  output reg_write_s       reg_wr,
  output logic [15:0]      param_num
);
  byte_t       frame_r [`BUF_DEPTH];
  logic [7:0]  rx_len_r;
  logic        rx_ovf_r;
  state_e      state_r;
  state_e      state_nxt;
  byte_t       func_r;
  byte_t       exc_code_r;
  logic        bcast_r;
  logic [15:0] start_r;
  logic [15:0] qty_r;
  logic [7:0]  resp_len_r;
  logic [7:0]  step_r;
  logic [31:0] coils_r;
  logic [15:0] crc;
  logic [15:0] rd_word;
  tx_byte_s    tx_r;
  reg_write_s  reg_wr_r;
  logic [15:0] param_num_r;

  function automatic logic [15:0] word_at(input logic [5:0] i);
    return {frame_r[i], frame_r[6'(i + 6'd1)]};
  endfunction : word_at

  // request fields
  logic [15:0] hdr_start;
  logic [15:0] hdr_qty;
  byte_t       hdr_bc;
  logic [16:0] range_end;
  logic        crc_ok;
  logic        addr_hit;
  logic        is_bcast;
  byte_t       chk_code;

  assign hdr_start = word_at(6'd2);
  assign hdr_qty   = word_at(6'd4);
  assign hdr_bc    = frame_r[6];
  assign range_end = {1'b0, hdr_start} + {1'b0, hdr_qty};
  assign crc_ok    = (rx_len_r >= `MIN_FRAME) && !rx_ovf_r && (crc == 16'h0000);
  assign addr_hit  = frame_r[0] == slave_addr;
  assign is_bcast  = frame_r[0] == `BCAST_ADDR;

  // validity of structure and range
  always_comb begin
    chk_code = `EXC_NONE;
    case (frame_r[1])
      `FC_RD_HOLD: begin
        if (rx_len_r != `FIXED_LEN || hdr_qty == 16'h0000 || hdr_qty > `MAX_QTY) begin
          chk_code = `EXC_ILL_VAL;
        end else if (range_end > {1'b0, `NUM_REGS}) begin
          chk_code = `EXC_ILL_ADDR;
        end
      end
      `FC_WR_SINGLE: begin
        if (rx_len_r != `FIXED_LEN) begin
          chk_code = `EXC_ILL_VAL;
        end else if (hdr_start >= `NUM_REGS) begin
          chk_code = `EXC_ILL_ADDR;
        end
      end
      `FC_WR_MULTI: begin
        if (hdr_qty == 16'h0000 || hdr_qty > `MAX_QTY
            || {8'h00, hdr_bc} != {hdr_qty[14:0], 1'b0}
            || {1'b0, rx_len_r} != `HDR_LEN + {1'b0, hdr_bc}) begin
          chk_code = `EXC_ILL_VAL;
        end else if (range_end > {1'b0, `NUM_REGS}) begin
          chk_code = `EXC_ILL_ADDR;
        end
      end
      `FC_WR_COILS: begin
        if (hdr_qty == 16'h0000 || hdr_qty > `NUM_COILS
            || {8'h00, hdr_bc} != ((hdr_qty + 16'h0007) >> 3)
            || {1'b0, rx_len_r} != `HDR_LEN + {1'b0, hdr_bc}) begin
          chk_code = `EXC_ILL_VAL;
        end else if (range_end > {1'b0, `NUM_COILS}) begin
          chk_code = `EXC_ILL_ADDR;
        end
      end
      default: begin
        chk_code = `EXC_ILL_FUNC;
      end
    endcase
  end

  // execution step and send bookkeeping
  logic [7:0] exec_last;
  logic       exec_done;
  logic       send_more;
  logic       tx_load;
  logic       tx_taken;

  assign exec_last = (func_r == `FC_WR_SINGLE) ? 8'h00 : 8'(qty_r - 16'h0001);
  assign exec_done = step_r == exec_last;
  assign send_more = step_r != 8'(resp_len_r + 8'h02);
  assign tx_load   = (state_r == ST_SEND) && send_more && (!tx_r.valid || tx_ready);
  assign tx_taken  = tx_r.valid && tx_ready;

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE: begin
        if (rx.frame_end) begin
          state_nxt = ST_CHECK;
        end
      end
      ST_CHECK: begin
        if (!crc_ok || !(addr_hit || is_bcast)) begin
          state_nxt = ST_IDLE;
        end else if (is_bcast && (frame_r[1] == `FC_RD_HOLD || chk_code != `EXC_NONE)) begin
          state_nxt = ST_IDLE;
        end else if (chk_code != `EXC_NONE || frame_r[1] == `FC_RD_HOLD) begin
          state_nxt = ST_SEND;
        end else begin
          state_nxt = ST_EXEC;
        end
      end
      ST_EXEC: begin
        if (exec_done) begin
          state_nxt = bcast_r ? ST_IDLE : ST_SEND;
        end
      end
      ST_SEND: begin
        if (tx_taken && tx_r.last) begin
          state_nxt = ST_IDLE;
        end
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      state_r <= ST_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // frame capture
  logic back_to_idle;
  assign back_to_idle = (state_r != ST_IDLE) && (state_nxt == ST_IDLE);

  always_ff @(posedge clk) begin
    if (reset || back_to_idle) begin
      rx_len_r <= 8'h00;
      rx_ovf_r <= 1'b0;
    end else if (state_r == ST_IDLE && rx.valid) begin
      if (rx_len_r == 8'(`BUF_DEPTH)) begin
        rx_ovf_r <= 1'b1;
      end else begin
        frame_r[rx_len_r[5:0]] <= rx.data;
        rx_len_r               <= rx_len_r + 8'h01;
      end
    end
  end

  // request latch
  always_ff @(posedge clk) begin
    if (reset) begin
      func_r     <= 8'h00;
      exc_code_r <= `EXC_NONE;
      bcast_r    <= 1'b0;
      start_r    <= 16'h0000;
      qty_r      <= 16'h0000;
      resp_len_r <= 8'h00;
    end else if (state_r == ST_CHECK) begin
      func_r     <= frame_r[1];
      exc_code_r <= chk_code;
      bcast_r    <= is_bcast;
      start_r    <= hdr_start;
      qty_r      <= hdr_qty;
      if (chk_code != `EXC_NONE) begin
        resp_len_r <= `RESP_EXC_LEN;
      end else if (frame_r[1] == `FC_RD_HOLD) begin
        resp_len_r <= 8'(`RESP_EXC_LEN + {hdr_qty[6:0], 1'b0});
      end else begin
        resp_len_r <= `RESP_ECHO_LEN;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset || state_r == ST_CHECK || (state_r == ST_EXEC && exec_done)) begin
      step_r <= 8'h00; // reply counts from the address byte
    end else if ((state_r == ST_EXEC && !exec_done) || tx_load) begin
      step_r <= step_r + 8'h01;
    end
  end

  // register writes
  logic        reg_we;
  logic [5:0]  reg_waddr;
  logic [15:0] reg_wdata;
  logic [5:0]  data_base;

  assign reg_we    = (state_r == ST_EXEC) && (func_r != `FC_WR_COILS);
  assign reg_waddr = 6'(start_r[5:0] + step_r[5:0]);
  assign data_base = (func_r == `FC_WR_SINGLE) ? 6'd4 : 6'd7;
  assign reg_wdata = word_at(6'(data_base + {step_r[4:0], 1'b0}));

  always_ff @(posedge clk) begin
    if (reset) begin
      reg_wr_r <= '0;
    end else begin
      reg_wr_r.valid <= reg_we;
      reg_wr_r.addr  <= {10'h000, reg_waddr};
      reg_wr_r.data  <= reg_wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      param_num_r <= 16'h0000;
    end else if (state_r == ST_CHECK && state_nxt != ST_IDLE && chk_code == `EXC_NONE
                 && frame_r[1] != `FC_WR_COILS) begin
      param_num_r <= hdr_start / `PARAM_STRIDE;
    end
  end

  // coil writes, broadcast or addressed alike
  logic       coil_we;
  logic [4:0] coil_idx;
  logic       coil_val;

  assign coil_we  = (state_r == ST_EXEC) && (func_r == `FC_WR_COILS);
  assign coil_idx = 5'(start_r[4:0] + step_r[4:0]);
  assign coil_val = frame_r[6'(6'd7 + {3'b000, step_r[5:3]})][step_r[2:0]];

  always_ff @(posedge clk) begin
    if (reset) begin
      coils_r <= 32'h0000_0000;
    end else if (coil_we) begin
      coils_r[coil_idx] <= coil_val;
    end
  end

  // reply byte generator
  logic [7:0] rd_off;
  logic [5:0] rd_addr;
  byte_t      gen_byte;

  assign rd_off  = 8'(step_r - 8'h03);
  assign rd_addr = 6'(start_r[5:0] + rd_off[6:1]);

  always_comb begin
    gen_byte = frame_r[step_r[5:0]];
    if (step_r == resp_len_r) begin
      gen_byte = crc[7:0];
    end else if (step_r > resp_len_r) begin
      gen_byte = crc[15:8];
    end else if (step_r == 8'h01 && exc_code_r != `EXC_NONE) begin
      gen_byte = func_r | `EXC_FLAG;
    end else if (step_r == 8'h02 && exc_code_r != `EXC_NONE) begin
      gen_byte = exc_code_r;
    end else if (func_r == `FC_RD_HOLD && exc_code_r == `EXC_NONE && step_r >= 8'h02) begin
      if (step_r == 8'h02) begin
        gen_byte = 8'({qty_r[6:0], 1'b0});
      end else begin
        gen_byte = rd_off[0] ? rd_word[7:0] : rd_word[15:8];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      tx_r <= '0;
    end else if (tx_load) begin
      tx_r.valid <= 1'b1;
      tx_r.data  <= gen_byte;
      tx_r.last  <= step_r == 8'(resp_len_r + 8'h01);
    end else if (tx_taken) begin
      tx_r <= '0;
    end
  end

  crc16_unit u_crc (
    .clk   (clk),
    .reset (reset),
    .clr   (state_r == ST_CHECK || back_to_idle),
    .en    ((state_r == ST_IDLE && rx.valid && !rx_ovf_r)
            || (tx_load && step_r < resp_len_r)),
    .data  ((state_r == ST_IDLE) ? rx.data : gen_byte),
    .crc   (crc)
  );

  holding_reg_file u_regs (
    .clk   (clk),
    .reset (reset),
    .we    (reg_we),
    .waddr (reg_waddr),
    .wdata (reg_wdata),
    .raddr (rd_addr),
    .rdata (rd_word)
  );

  assign tx        = tx_r;
  assign coils     = coils_r;
  assign reg_wr    = reg_wr_r;
  assign param_num = param_num_r;

  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  bad_check_drop_a: assert property ((state_r == ST_CHECK) && !crc_ok |=> state_r == ST_IDLE)
    else $error("bad check frame not dropped");
  bcast_read_drop_a: assert property (
    (state_r == ST_CHECK) && crc_ok && is_bcast && frame_r[1] == `FC_RD_HOLD
    |=> state_r == ST_IDLE)
    else $error("broadcast read was taken");
  bcast_silent_a: assert property ((state_r == ST_EXEC) && bcast_r |-> !tx.valid [*6])
    else $error("broadcast got a reply");
  echo_addr_a: assert property (tx_load && step_r == 8'h00 |=> tx.data == slave_addr)
    else $error("reply address wrong");
  echo_func_a: assert property (
    tx_load && step_r == 8'h01 && exc_code_r == `EXC_NONE |=> tx.data == func_r)
    else $error("reply function wrong");
  read_count_a: assert property (
    tx_load && step_r == 8'h02 && func_r == `FC_RD_HOLD && exc_code_r == `EXC_NONE
    |=> tx.data == 8'({qty_r[6:0], 1'b0}))
    else $error("byte count wrong");
  range_exc_a: assert property (
    (state_r == ST_CHECK) && crc_ok && addr_hit && !is_bcast && frame_r[1] == `FC_RD_HOLD
    && rx_len_r == `FIXED_LEN && hdr_qty != 16'h0000 && hdr_qty <= `MAX_QTY
    && range_end > {1'b0, `NUM_REGS}
    |=> exc_code_r == `EXC_ILL_ADDR ##1 state_r == ST_SEND)
    else $error("range exception missing");
  coil_apply_a: assert property (coil_we |=> coils_r[$past(coil_idx)] == $past(coil_val))
    else $error("coil not forced");
  reg_addr_a: assert property (reg_we |=> reg_wr.valid && reg_wr.addr[15:6] == 10'h000
    && reg_wr.addr[5:0] == 6'(start_r[5:0] + 6'($past(step_r))))
    else $error("register write address wrong");
  write_first_a: assert property ((state_r == ST_EXEC) && !bcast_r && exec_done
    |=> state_r == ST_SEND && !tx.valid)
    else $error("reply before write");

  read_reply_c: cover property ((state_r == ST_SEND) && func_r == `FC_RD_HOLD && tx.last);
  multi_write_c: cover property ((state_r == ST_EXEC) && func_r == `FC_WR_MULTI && exec_done);
  coil_setpt_c: cover property (coil_we && coil_idx == 5'd16);
  exc_reply_c: cover property ((state_r == ST_SEND) && exc_code_r != `EXC_NONE);
endmodule : modbus_rtu_function_handler

// [test/rtu_master_model.sv]
// Purpose: master side of the serial link, sends requests and takes replies
// Assumes: one byte per cycle on the receive strobe, frame end pulse after the last byte
// Notes: drives its lines only at the falling edge; idle data never repeats the last byte
`timescale 1ns/1ps
module rtu_master_model
  import modbus_pkg::*;
(
  // clock
  input  wire logic     clk,
  // link toward the handler
  output rx_byte_s      rx,
  input  wire tx_byte_s tx,
  output logic          tx_ready
);
  byte_t last_b;

  initial begin
    rx       = '0;
    tx_ready = 1'b0;
    last_b   = 8'h00;
  end

  function automatic logic [15:0] crc16(input byte_t q[$]);
    logic [15:0] c;
    c = 16'hffff;
    foreach (q[i]) begin
      c = c ^ {8'h00, q[i]};
      for (int k = 0; k < 8; k++) begin
        c = c[0] ? ((c >> 1) ^ 16'ha001) : (c >> 1);
      end
    end
    return c;
  endfunction : crc16

  // frame out, check field low byte first; bad flips one bit of it
  task automatic send(input byte_t q[$], input bit bad);
    logic [15:0] c;
    c = crc16(q);
    q.push_back(c[7:0] ^ {7'h00, bad});
    q.push_back(c[15:8]);
    foreach (q[i]) begin
      @(negedge clk);
      rx     <= '{valid: 1'b1, data: q[i], frame_end: 1'b0};
      last_b = q[i];
    end
    @(negedge clk);
    rx <= '{valid: 1'b0, data: ~last_b, frame_end: 1'b1};
    @(negedge clk);
    rx <= '{valid: 1'b0, data: last_b ^ 8'h5a, frame_end: 1'b0};
  endtask : send

  // reply in; slow accepts one byte in three, empty result when none comes
  task automatic get_reply(input bit slow, output byte_t q[$]);
    int n;
    q = {};
    for (n = 0; n < 60; n++) begin
      @(negedge clk);
      tx_ready = !slow || (n % 3 == 2);
      if (tx.valid === 1'b1 && tx_ready) begin
        q.push_back(tx.data);
        if (tx.last === 1'b1) break;
      end
    end
  endtask : get_reply
endmodule : rtu_master_model

// [test/tb_top.sv]
// Purpose: self-checking bench of the request handler
// Assumes: station address 01, broadcast 00, 64 registers, 32 coils
// Notes: expected replies are built here, check fields by the master model
`timescale 1ns/1ps
module tb_top
  import modbus_pkg::*;
;
  logic        clk;
  logic        reset;
  byte_t       slave_addr;
  rx_byte_s    rx;
  tx_byte_s    tx;
  logic        tx_ready;
  coil_image_s coils;
  reg_write_s  reg_wr;
  logic [15:0] param_num;
  int          failures;
  int          tests_run;
  logic [31:0] wq[$];

  initial clk = 1'b0;
  always #4 clk = ~clk;

  modbus_rtu_function_handler u_modbus_rtu_function_handler (
    .clk(clk), .reset(reset), .slave_addr(slave_addr), .rx(rx), .tx(tx),
    .tx_ready(tx_ready), .coils(coils), .reg_wr(reg_wr), .param_num(param_num));

  rtu_master_model u_rtu_master_model (
    .clk(clk), .rx(rx), .tx(tx), .tx_ready(tx_ready));

  // register write log
  always @(negedge clk) begin
    if (reg_wr.valid === 1'b1) wq.push_back({reg_wr.addr, reg_wr.data});
  end

  task automatic check(string what, logic [31:0] exp, logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic stop_test;
    $display("checks %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : stop_test

  // request out, reply compared byte by byte with its check field
  task automatic xfer(input byte_t q[$], input bit bad, input bit slow, input byte_t e[$]);
    byte_t       g[$];
    logic [15:0] c;
    u_rtu_master_model.send(q, bad);
    u_rtu_master_model.get_reply(slow, g);
    if (e.size() > 0) begin
      c = u_rtu_master_model.crc16(e);
      e.push_back(c[7:0]);
      e.push_back(c[15:8]);
    end
    check("reply length", 32'(e.size()), 32'(g.size()));
    foreach (e[i]) begin
      if (i < g.size()) check("reply byte", {24'h0, e[i]}, {24'h0, g[i]});
    end
  endtask : xfer

  task automatic t_reset;
    check("tx idle", 32'h0, {23'h0, tx.valid, tx.data});
    check("coils", 32'h0, coils);
    check("param", 32'h0, {16'h0, param_num});
    $display("test reset values done");
  endtask : t_reset

  task automatic t_single;
    wq = {};
    // register 21 travels as 20
    xfer('{8'h01, 8'h06, 8'h00, 8'h14, 8'h12, 8'h34}, 1'b0, 1'b0,
         '{8'h01, 8'h06, 8'h00, 8'h14, 8'h12, 8'h34});
    check("single write", 32'h0014_1234, wq.size() > 0 ? wq[0] : 32'h0);
    check("single count", 32'd1, 32'(wq.size()));
    check("param", 32'h2, {16'h0, param_num});
    $display("test preset single done");
  endtask : t_single

  task automatic t_multi;
    wq = {};
    xfer('{8'h01, 8'h10, 8'h00, 8'h0a, 8'h00, 8'h02, 8'h04, 8'h00, 8'h00, 8'h02, 8'he2},
         1'b0, 1'b0, '{8'h01, 8'h10, 8'h00, 8'h0a, 8'h00, 8'h02});
    check("multi words", 32'd2, 32'(wq.size()));
    check("multi first", 32'h000a_0000, wq.size() > 0 ? wq[0] : 32'h0);
    check("multi second", 32'h000b_02e2, wq.size() > 1 ? wq[1] : 32'h0);
    check("param", 32'h1, {16'h0, param_num});
    // 32-bit value read back as two registers with a stalling master
    xfer('{8'h01, 8'h03, 8'h00, 8'h0a, 8'h00, 8'h02}, 1'b0, 1'b1,
         '{8'h01, 8'h03, 8'h04, 8'h00, 8'h00, 8'h02, 8'he2});
    xfer('{8'h01, 8'h03, 8'h00, 8'h14, 8'h00, 8'h01}, 1'b0, 1'b0,
         '{8'h01, 8'h03, 8'h02, 8'h12, 8'h34});
    $display("test preset multiple and read done");
  endtask : t_multi

  task automatic t_coils;
    // coils 17..32 travel as 16..31
    xfer('{8'h01, 8'h0f, 8'h00, 8'h10, 8'h00, 8'h10, 8'h02, 8'h20, 8'h00}, 1'b0, 1'b0,
         '{8'h01, 8'h0f, 8'h00, 8'h10, 8'h00, 8'h10});
    check("setpoint", 32'h0020, {16'h0, coils.setpoint});
    check("ctrl kept", 32'h0, {16'h0, coils.ctrl});
    $display("test coil write done");
  endtask : t_coils

  task automatic t_bcast;
    wq = {};
    xfer('{8'h00, 8'h0f, 8'h00, 8'h00, 8'h00, 8'h10, 8'h02, 8'h55, 8'haa}, 1'b0, 1'b0,
         '{});
    check("bcast ctrl", 32'haa55, {16'h0, coils.ctrl});
    check("bcast setpoint", 32'h0020, {16'h0, coils.setpoint});
    xfer('{8'h00, 8'h06, 8'h00, 8'h01, 8'h00, 8'h07}, 1'b0, 1'b0, '{});
    check("bcast write", 32'h0001_0007, wq.size() > 0 ? wq[0] : 32'h0);
    xfer('{8'h00, 8'h03, 8'h00, 8'h00, 8'h00, 8'h01}, 1'b0, 1'b0, '{});
    $display("test broadcast done");
  endtask : t_bcast

  task automatic t_range;
    xfer('{8'h01, 8'h03, 8'h00, 8'h3e, 8'h00, 8'h02}, 1'b0, 1'b0,
         '{8'h01, 8'h03, 8'h04, 8'h00, 8'h00, 8'h00, 8'h00});
    xfer('{8'h01, 8'h03, 8'h00, 8'h3e, 8'h00, 8'h03}, 1'b0, 1'b0,
         '{8'h01, 8'h83, 8'h02});
    xfer('{8'h01, 8'h10, 8'h00, 8'h3f, 8'h00, 8'h02, 8'h04, 8'h00, 8'h01, 8'h00, 8'h02},
         1'b0, 1'b0, '{8'h01, 8'h90, 8'h02});
    // unsupported function and zero quantity give codes one and three
    xfer('{8'h01, 8'h05, 8'h00, 8'h40, 8'hff, 8'h00}, 1'b0, 1'b0,
         '{8'h01, 8'h85, 8'h01});
    xfer('{8'h01, 8'h03, 8'h00, 8'h00, 8'h00, 8'h00}, 1'b0, 1'b0,
         '{8'h01, 8'h83, 8'h03});
    $display("test address range done");
  endtask : t_range

  task automatic t_drop;
    wq = {};
    xfer('{8'h01, 8'h06, 8'h00, 8'h05, 8'hab, 8'hcd}, 1'b1, 1'b0, '{});
    xfer('{8'h02, 8'h06, 8'h00, 8'h05, 8'hab, 8'hcd}, 1'b0, 1'b0, '{});
    check("dropped writes", 32'd0, 32'(wq.size()));
    // last request taken without exception started at register 63
    check("param kept", 32'h6, {16'h0, param_num});
    $display("test dropped frames done");
  endtask : t_drop

  initial begin
    reset      = 1'b1;
    slave_addr = 8'h01;
    failures   = 0;
    tests_run  = 0;
    repeat (10) @(negedge clk);
    reset = 1'b0;
    t_reset;
    t_single;
    t_multi;
    t_coils;
    t_bcast;
    t_range;
    t_drop;
    stop_test;
  end

  // about 600 cycles expected; cut off far beyond that
  initial begin
    #200000;
    failures++;
    stop_test;
  end
endmodule : tb_top
